// file: hdl/cpm_regs.sv
// Programming model register state of the core: general registers,
// stack pointers, status word, vector base and alternate space codes.
// Assumes the core's execute logic drives every request on clk_in.
`timescale 1ns/1ps
// Summary of operation
// - Byte or word data writes change only the low 8 or 16 bits.
// - Bit 0 is least significant, bit 31 most significant.
// - Address register writes set all 32 bits; word sources are sign-extended.
// - Address registers refuse byte size; reads give low word or long.
// - Stack alias selects user or supervisor stack by privilege.
// - Any of the 16 general registers can be an index.
// - Status word undefined bits read zero.
// - Condition code byte accesses read zero upper byte, ignore it on write.
// - Status word and condition code byte move as words.
// - User level reaches only the condition code byte.
// - Status word holds codes, three-bit mask, trace and privilege bits.
// - Space code registers keep bits 2:0; upper 29 read zero.
// - Vector address is base register plus displacement.
// - Every access carries a 3-bit address-space code.
// - Memory is big-endian, byte addressed.
// - Word and long operands must be word aligned.
// - A decimal byte holds two digits, low digit in low nibble.
// - A 64-bit result may go to any two data registers.
module cpm_regs #(
  parameter int VEC_DISP_W = 10
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    ce_in,
  input  wire logic                    gp_rd_en_in,
  input  wire logic [3:0]              gp_rd_sel_in,
  input  wire cpm_pkg::cpm_size_t      gp_rd_size_in,
  output logic      [31:0]             gp_rd_data_out,
  output logic                         gp_rd_err_out,
  input  wire logic [3:0]              idx_sel_in,
  input  wire logic                    idx_long_in,
  output logic      [31:0]             idx_data_out,
  input  wire cpm_pkg::cpm_gp_wr_t     gp_wr_in,
  output logic                         gp_wr_err_out,
  input  wire logic                    quad_en_in,
  input  wire logic [2:0]              quad_hi_sel_in,
  input  wire logic [2:0]              quad_lo_sel_in,
  input  wire logic [63:0]             quad_data_in,
  input  wire cpm_pkg::cpm_ctl_req_t   ctl_req_in,
  output logic      [31:0]             ctl_rdata_out,
  output logic                         ctl_priv_err_out,
  input  wire logic                    cc_we_in,
  input  wire logic [4:0]              cc_in,
  output logic      [15:0]             status_word_out,
  output logic                         supervisor_out,
  input  wire logic                    vec_req_in,
  input  wire logic [VEC_DISP_W-1:0]   vec_disp_in,
  output logic      [31:0]             vec_addr_out,
  input  wire cpm_pkg::cpm_acc_t       acc_type_in,
  output logic      [2:0]              space_code_out,
  input  wire logic                    mem_req_in,
  input  wire logic [1:0]              mem_addr_lo_in,
  input  wire cpm_pkg::cpm_size_t      mem_size_in,
  input  wire logic [31:0]             mem_data_in,
  output logic                         mem_valid_out,
  output logic      [31:0]             mem_lane_out,
  output logic      [3:0]              mem_be_out,
  output logic                         mem_misalign_out,
  output logic      [3:0]              bcd_hi_out,
  output logic      [3:0]              bcd_lo_out
);

  logic [15:0] status_word;
  logic [15:0] next_status_word;
  logic [31:0] vector_table_base;
  logic [31:0] next_vector_table_base;
  logic [2:0]  source_space_code;
  logic [2:0]  next_source_space_code;
  logic [2:0]  dest_space_code;
  logic [2:0]  next_dest_space_code;
  logic [31:0] next_ctl_rdata;
  logic        next_priv_err;
  logic        super_mode;
  logic        wa_en;
  logic        wb_en;
  logic [4:0]  wa_idx;
  logic [4:0]  wb_idx;
  logic [3:0]  wa_be;
  logic [31:0] wa_data;
  logic [31:0] wb_data;
  logic        next_wr_err;
  logic [31:0] ra_data;
  logic [31:0] rb_data;
  logic        rd_en_q;
  logic        next_rd_en_q;
  logic        rd_addr_q;
  logic        next_rd_addr_q;
  cpm_pkg::cpm_size_t rd_size_q;
  cpm_pkg::cpm_size_t next_rd_size_q;
  logic        idx_long_q;
  logic        next_idx_long_q;
  logic [31:0] next_rd_data;
  logic        next_rd_err;
  logic [31:0] next_idx_data;
  logic [31:0] next_vec_addr;
  logic [2:0]  next_space_code;

  // privilege bit drives aliasing and space codes
  assign super_mode      = status_word[cpm_pkg::CPM_SW_S];
  assign status_word_out = status_word;
  assign supervisor_out  = super_mode;

  function automatic logic [4:0] phys_idx(input logic [3:0] sel, input logic s);
    if (sel == cpm_pkg::CPM_ALIAS_SEL) begin
      return s ? cpm_pkg::CPM_SSTK_IDX : cpm_pkg::CPM_USTK_IDX;
    end
    return {1'b0, sel};
  endfunction

  // Write port steering; a 64-bit result takes both ports and wins
  always_comb begin
    wa_en       = 1'b0;
    wb_en       = 1'b0;
    wa_idx      = phys_idx(gp_wr_in.sel, super_mode);
    wb_idx      = {2'b00, quad_lo_sel_in};
    wa_be       = 4'hF;
    wa_data     = gp_wr_in.data;
    wb_data     = quad_data_in[31:0];
    next_wr_err = 1'b0;
    if (quad_en_in) begin
      wa_en       = 1'b1;
      wb_en       = 1'b1;
      wa_idx      = {2'b00, quad_hi_sel_in};
      wa_data     = quad_data_in[63:32];
      next_wr_err = gp_wr_in.en;
    end else if (gp_wr_in.en && gp_wr_in.sel[3]) begin
      if (gp_wr_in.size == cpm_pkg::CPM_SZ_BYTE) begin
        next_wr_err = 1'b1;
      end else begin
        wa_en = 1'b1;
        if (gp_wr_in.size == cpm_pkg::CPM_SZ_WORD) begin
          wa_data = {{16{gp_wr_in.data[15]}}, gp_wr_in.data[15:0]};
        end
      end
    end else if (gp_wr_in.en) begin
      wa_en = 1'b1;
      unique case (gp_wr_in.size)
        cpm_pkg::CPM_SZ_BYTE: wa_be = 4'h1;
        cpm_pkg::CPM_SZ_WORD: wa_be = 4'h3;
        default:              wa_be = 4'hF;
      endcase
    end
  end

  // index read on its own port
  cpm_gpr_mem #(
    .DEPTH (cpm_pkg::CPM_GPR_DEPTH),
    .AW    (cpm_pkg::CPM_GPR_AW)
  ) u_gpr (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .wa_en_in    (wa_en),
    .wa_idx_in   (wa_idx),
    .wa_be_in    (wa_be),
    .wa_data_in  (wa_data),
    .wb_en_in    (wb_en),
    .wb_idx_in   (wb_idx),
    .wb_data_in  (wb_data),
    .ra_idx_in   (phys_idx(gp_rd_sel_in, super_mode)),
    .ra_data_out (ra_data),
    .rb_idx_in   (phys_idx(idx_sel_in, super_mode)),
    .rb_data_out (rb_data)
  );

  // Read sizing, second stage so the outputs leave flip-flops
  always_comb begin
    next_rd_en_q    = gp_rd_en_in;
    next_rd_addr_q  = gp_rd_sel_in[3];
    next_rd_size_q  = gp_rd_size_in;
    next_idx_long_q = idx_long_in;
    next_rd_err     = 1'b0;
    // bit 0 is the LSB throughout
    unique case (rd_size_q)
      cpm_pkg::CPM_SZ_BYTE: begin
        next_rd_data = rd_addr_q ? '0 : 32'(ra_data[7:0]);
        next_rd_err  = rd_en_q && rd_addr_q;
      end
      cpm_pkg::CPM_SZ_WORD: next_rd_data = 32'(ra_data[15:0]);
      default:              next_rd_data = ra_data;
    endcase
    next_idx_data = idx_long_q ? rb_data : {{16{rb_data[15]}}, rb_data[15:0]};
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_en_q        <= 1'b0;
      rd_addr_q      <= 1'b0;
      rd_size_q      <= cpm_pkg::CPM_SZ_LONG;
      idx_long_q     <= 1'b1;
      gp_rd_data_out <= '0;
      gp_rd_err_out  <= 1'b0;
      idx_data_out   <= '0;
      gp_wr_err_out  <= 1'b0;
    end else if (ce_in) begin
      rd_en_q        <= next_rd_en_q;
      rd_addr_q      <= next_rd_addr_q;
      rd_size_q      <= next_rd_size_q;
      idx_long_q     <= next_idx_long_q;
      gp_rd_data_out <= next_rd_data;
      gp_rd_err_out  <= next_rd_err;
      idx_data_out   <= next_idx_data;
      gp_wr_err_out  <= next_wr_err;
    end
  end

  // Control registers; an explicit move beats a same-cycle code update
  always_comb begin
    next_status_word       = status_word;
    next_vector_table_base = vector_table_base;
    next_source_space_code = source_space_code;
    next_dest_space_code   = dest_space_code;
    next_ctl_rdata         = '0;
    next_priv_err          = 1'b0;
    if (cc_we_in) begin
      next_status_word[cpm_pkg::CPM_CC_W-1:0] = cc_in;
    end
    // user level gets the code byte only
    if (ctl_req_in.en && !super_mode && ctl_req_in.sel != cpm_pkg::CPM_CTL_CODE) begin
      next_priv_err = 1'b1;
    end else if (ctl_req_in.en) begin
      unique case (ctl_req_in.sel)
        cpm_pkg::CPM_CTL_CODE: begin
          next_ctl_rdata = 32'(status_word[7:0]);
          if (ctl_req_in.wr) begin
            next_status_word[7:0] = ctl_req_in.data[7:0] & cpm_pkg::CPM_SW_MASK[7:0];
          end
        end
        cpm_pkg::CPM_CTL_STAT: begin
          next_ctl_rdata = 32'(status_word);
          if (ctl_req_in.wr) begin
            next_status_word = ctl_req_in.data[15:0] & cpm_pkg::CPM_SW_MASK;
          end
        end
        cpm_pkg::CPM_CTL_VBASE: begin
          next_ctl_rdata = vector_table_base;
          if (ctl_req_in.wr) begin
            next_vector_table_base = ctl_req_in.data;
          end
        end
        cpm_pkg::CPM_CTL_SRC: begin
          next_ctl_rdata = 32'(source_space_code);
          if (ctl_req_in.wr) begin
            next_source_space_code = ctl_req_in.data[2:0];
          end
        end
        cpm_pkg::CPM_CTL_DST: begin
          next_ctl_rdata = 32'(dest_space_code);
          if (ctl_req_in.wr) begin
            next_dest_space_code = ctl_req_in.data[2:0];
          end
        end
        default: next_priv_err = 1'b1; // Unassigned selector codes
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_word       <= cpm_pkg::CPM_SW_RESET;
      vector_table_base <= cpm_pkg::CPM_VBASE_RESET;
      source_space_code <= cpm_pkg::CPM_SPACE_RESET;
      dest_space_code   <= cpm_pkg::CPM_SPACE_RESET;
      ctl_rdata_out     <= '0;
      ctl_priv_err_out  <= 1'b0;
    end else if (ce_in) begin
      status_word       <= next_status_word;
      vector_table_base <= next_vector_table_base;
      source_space_code <= next_source_space_code;
      dest_space_code   <= next_dest_space_code;
      ctl_rdata_out     <= next_ctl_rdata;
      ctl_priv_err_out  <= next_priv_err;
    end
  end

  // Vector location and address-space code
  always_comb begin
    next_vec_addr = vec_req_in ? vector_table_base + 32'(vec_disp_in) : vec_addr_out;
    unique case (acc_type_in)
      cpm_pkg::CPM_ACC_DATA:    next_space_code = {super_mode, cpm_pkg::CPM_FC_DATA_LOW};
      cpm_pkg::CPM_ACC_PROG:    next_space_code = {super_mode, cpm_pkg::CPM_FC_PROG_LOW};
      cpm_pkg::CPM_ACC_ALT_SRC: next_space_code = source_space_code;
      cpm_pkg::CPM_ACC_ALT_DST: next_space_code = dest_space_code;
      default:                  next_space_code = cpm_pkg::CPM_FC_CPU;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vec_addr_out   <= '0;
      space_code_out <= cpm_pkg::CPM_FC_CPU;
    end else if (ce_in) begin
      vec_addr_out   <= next_vec_addr;
      space_code_out <= next_space_code;
    end
  end

  // Memory operand lanes and decimal digits
  cpm_lane_fmt u_lane (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .req_in        (mem_req_in),
    .addr_lo_in    (mem_addr_lo_in),
    .size_in       (mem_size_in),
    .data_in       (mem_data_in),
    .valid_out     (mem_valid_out),
    .lane_data_out (mem_lane_out),
    .lane_be_out   (mem_be_out),
    .misalign_out  (mem_misalign_out),
    .bcd_hi_out    (bcd_hi_out),
    .bcd_lo_out    (bcd_lo_out)
  );

  // Checks on the driven state
  AST_SW_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (status_word_out & ~cpm_pkg::CPM_SW_MASK) == 16'h0000)
    else $error("status word reserved bit set");

  AST_CODE_KEEPS_UPPER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ctl_req_in.en && ctl_req_in.wr && ctl_req_in.sel == cpm_pkg::CPM_CTL_CODE
    |=> status_word_out[15:8] == $past(status_word_out[15:8]) && ctl_rdata_out[31:8] == '0)
    else $error("code byte access touched upper byte");

  AST_USER_REFUSED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    // A same-cycle code update may legally change the status word
    ce_in && !cc_we_in && ctl_req_in.en && !supervisor_out &&
    ctl_req_in.sel != cpm_pkg::CPM_CTL_CODE
    |=> ctl_priv_err_out && $stable(status_word_out) && ctl_rdata_out == '0)
    else $error("user access to control register not refused");

  AST_SPACE_UPPER_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ctl_req_in.en && supervisor_out &&
    (ctl_req_in.sel == cpm_pkg::CPM_CTL_SRC || ctl_req_in.sel == cpm_pkg::CPM_CTL_DST)
    |=> ctl_rdata_out[31:3] == '0)
    else $error("space code upper bits not zero");

  AST_VECTOR_SUM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && vec_req_in |=> vec_addr_out == $past(vector_table_base) + 32'($past(vec_disp_in)))
    else $error("vector location wrong");

  AST_ADDR_BYTE_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && gp_wr_in.en && !quad_en_in && gp_wr_in.sel[3] &&
    gp_wr_in.size == cpm_pkg::CPM_SZ_BYTE |=> gp_wr_err_out)
    else $error("byte write to address register not refused");

  AST_BYTE_READ_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && gp_rd_size_in == cpm_pkg::CPM_SZ_BYTE ##1 ce_in |=> gp_rd_data_out[31:8] == '0)
    else $error("byte read carries upper bits");

  AST_DATA_SPACE_CODE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && acc_type_in == cpm_pkg::CPM_ACC_DATA
    |=> space_code_out == {$past(supervisor_out), cpm_pkg::CPM_FC_DATA_LOW})
    else $error("data access space code wrong");

endmodule // cpm_regs

// file: hdl/cpm_pkg.sv
// Shared constants and types for the programming model register block.
// Assumes one core clock; every user of these names writes cpm_pkg::name.
package cpm_pkg;

  // Operand sizes
  typedef enum logic [1:0] {
    CPM_SZ_BYTE = 2'b00,
    CPM_SZ_WORD = 2'b01,
    CPM_SZ_LONG = 2'b10
  } cpm_size_t;

  // Control registers reachable by the control move port
  typedef enum logic [2:0] {
    CPM_CTL_CODE  = 3'b000,
    CPM_CTL_STAT  = 3'b001,
    CPM_CTL_VBASE = 3'b010,
    CPM_CTL_SRC   = 3'b011,
    CPM_CTL_DST   = 3'b100
  } cpm_ctl_t;

  // Access types that pick the address-space code
  typedef enum logic [2:0] {
    CPM_ACC_DATA    = 3'b000,
    CPM_ACC_PROG    = 3'b001,
    CPM_ACC_ALT_SRC = 3'b010,
    CPM_ACC_ALT_DST = 3'b011,
    CPM_ACC_CPU     = 3'b100
  } cpm_acc_t;

  // Status word layout
  localparam logic [15:0] CPM_SW_MASK  = 16'hE71F;
  localparam logic [15:0] CPM_SW_RESET = 16'h2700;
  localparam int          CPM_SW_S     = 13;
  localparam int          CPM_SW_T_LO  = 14;
  localparam int          CPM_SW_I_LO  = 8;
  localparam int          CPM_CC_W     = 5;
  localparam logic [31:0] CPM_VBASE_RESET = 32'h0000_0000;
  localparam logic [2:0]  CPM_SPACE_RESET = 3'h0;

  // Address-space codes
  localparam logic [1:0]  CPM_FC_DATA_LOW = 2'h1;
  localparam logic [1:0]  CPM_FC_PROG_LOW = 2'h2;
  localparam logic [2:0]  CPM_FC_CPU      = 3'h7;

  // General register file map
  localparam logic [3:0]  CPM_ALIAS_SEL = 4'hF;
  localparam logic [4:0]  CPM_USTK_IDX  = 5'h0F;
  localparam logic [4:0]  CPM_SSTK_IDX  = 5'h10;
  localparam int          CPM_GPR_DEPTH = 17;
  localparam int          CPM_GPR_AW    = 5;

  // General register write request
  typedef struct packed {
    logic      en;
    logic [3:0] sel;
    cpm_size_t size;
    logic [31:0] data;
  } cpm_gp_wr_t;

  // Control register move request
  typedef struct packed {
    logic      en;
    logic      wr;
    cpm_ctl_t  sel;
    logic [31:0] data;
  } cpm_ctl_req_t;

endpackage

// file: hdl/cpm_gpr_mem.sv
// General register storage: entries with two write and two read ports.
// Assumes index decode and stack aliasing are done by the parent.
`timescale 1ns/1ps
module cpm_gpr_mem #(
  parameter int DEPTH = 17,
  parameter int AW    = 5
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  input  wire logic          wa_en_in,
  input  wire logic [AW-1:0] wa_idx_in,
  input  wire logic [3:0]    wa_be_in,
  input  wire logic [31:0]   wa_data_in,
  input  wire logic          wb_en_in,
  input  wire logic [AW-1:0] wb_idx_in,
  input  wire logic [31:0]   wb_data_in,
  input  wire logic [AW-1:0] ra_idx_in,
  output logic      [31:0]   ra_data_out,
  input  wire logic [AW-1:0] rb_idx_in,
  output logic      [31:0]   rb_data_out
);

  // Unpacked so each entry's processes own their own element
  logic [31:0]            mem      [DEPTH];
  logic [31:0]            next_mem [DEPTH];
  logic [31:0]            next_ra;
  logic [31:0]            next_rb;

  // One entry per step; port a wins a same-entry collision byte by byte
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      next_mem[i] = mem[i];
      if (wb_en_in && wb_idx_in == AW'(i)) begin
        next_mem[i] = wb_data_in;
      end
      for (int b = 0; b < 4; b++) begin
        if (wa_en_in && wa_idx_in == AW'(i) && wa_be_in[b]) begin
          next_mem[i][8*b +: 8] = wa_data_in[8*b +: 8];
        end
      end
    end

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        mem[i] <= '0;
      end else if (ce_in) begin
        mem[i] <= next_mem[i];
      end
    end
  end

  // Registered reads; an index past the table reads zero
  always_comb begin
    next_ra = (int'(ra_idx_in) < DEPTH) ? mem[ra_idx_in] : '0;
    next_rb = (int'(rb_idx_in) < DEPTH) ? mem[rb_idx_in] : '0;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ra_data_out <= '0;
      rb_data_out <= '0;
    end else if (ce_in) begin
      ra_data_out <= next_ra;
      rb_data_out <= next_rb;
    end
  end

endmodule // cpm_gpr_mem

// file: hdl/cpm_lane_fmt.sv
// Big-endian byte lane formatter for one memory operand, plus BCD split.
// Assumes the address low bits are the offset within a long-word slot.
`timescale 1ns/1ps
module cpm_lane_fmt (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 ce_in,
  input  wire logic                 req_in,
  input  wire logic [1:0]           addr_lo_in,
  input  wire cpm_pkg::cpm_size_t   size_in,
  input  wire logic [31:0]          data_in,
  output logic                      valid_out,
  output logic      [31:0]          lane_data_out,
  output logic      [3:0]           lane_be_out,
  output logic                      misalign_out,
  output logic      [3:0]           bcd_hi_out,
  output logic      [3:0]           bcd_lo_out
);

  logic [31:0] next_lane;
  logic [3:0]  next_be;
  logic        next_mis;

  // most significant byte first
  // Lane bits 31:24 carry offset 0; a long at offset 2 wraps into the next slot
  always_comb begin
    next_mis = (size_in != cpm_pkg::CPM_SZ_BYTE) && addr_lo_in[0];
    unique case (size_in)
      cpm_pkg::CPM_SZ_BYTE: begin
        next_lane = {4{data_in[7:0]}};
        next_be   = 4'h8 >> addr_lo_in;
      end
      cpm_pkg::CPM_SZ_WORD: begin
        next_lane = {2{data_in[15:0]}};
        next_be   = addr_lo_in[1] ? 4'h3 : 4'hC;
      end
      default: begin
        next_lane = addr_lo_in[1] ? {data_in[15:0], data_in[31:16]} : data_in;
        next_be   = 4'hF;
      end
    endcase
    if (next_mis) begin
      next_be = 4'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      valid_out     <= 1'b0;
      lane_data_out <= '0;
      lane_be_out   <= '0;
      misalign_out  <= 1'b0;
      bcd_hi_out    <= '0;
      bcd_lo_out    <= '0;
    end else if (ce_in) begin
      valid_out <= req_in;
      if (req_in) begin
        lane_data_out <= next_lane;
        lane_be_out   <= next_be;
        misalign_out  <= next_mis;
        bcd_hi_out    <= data_in[7:4];
        bcd_lo_out    <= data_in[3:0];
      end
    end
  end

endmodule // cpm_lane_fmt

// file: testbench/tb_cpm_regs.sv
// Self-checking bench for the programming model register block.
// Assumes cpm_regs and cpm_pkg; inputs change on falling clock edges.
`timescale 1ns/1ps
module tb_cpm_regs;
  logic clk = 0, rst_n = 0, rd_en = 0, il = 0, qen = 0, ccwe = 0, vreq = 0, mreq = 0, ce = 1;
  logic [3:0] rsel = 0, be, bh, bl, b;
  logic [2:0] qh = 0, ql = 0, spc;
  logic [4:0] cc = 0;
  logic [9:0] disp = 0;
  logic [1:0] malo = 0, rd_p = 0;
  logic [31:0] mdat = 0, r, rdat, idat, crd, vaddr, lane, l;
  logic [63:0] qd = 0;
  logic [15:0] sw;
  logic rerr, werr, perr, sup, mval, mis, m, ctl_p = 0;
  logic [2:0] sx [5] = '{3'h5, 3'h6, 3'h5, 3'h2, 3'h7};
  cpm_pkg::cpm_size_t rsz = cpm_pkg::CPM_SZ_LONG, msz = cpm_pkg::CPM_SZ_LONG;
  cpm_pkg::cpm_gp_wr_t wr = '0;
  cpm_pkg::cpm_ctl_req_t ctl = '0;
  cpm_pkg::cpm_acc_t acc = cpm_pkg::CPM_ACC_CPU;
  logic [95:0] q_rd [$], q_ctl [$], q_ln [$];
  int n_fail = 0, samples_checked = 0, cyc = 0;

  cpm_regs u_dut (.clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .gp_rd_en_in(rd_en),
    .gp_rd_sel_in(rsel), .gp_rd_size_in(rsz), .gp_rd_data_out(rdat), .gp_rd_err_out(rerr),
    .idx_sel_in(rsel), .idx_long_in(il), .idx_data_out(idat), .gp_wr_in(wr),
    .gp_wr_err_out(werr), .quad_en_in(qen), .quad_hi_sel_in(qh), .quad_lo_sel_in(ql),
    .quad_data_in(qd), .ctl_req_in(ctl), .ctl_rdata_out(crd), .ctl_priv_err_out(perr),
    .cc_we_in(ccwe), .cc_in(cc), .status_word_out(sw), .supervisor_out(sup),
    .vec_req_in(vreq), .vec_disp_in(disp), .vec_addr_out(vaddr), .acc_type_in(acc),
    .space_code_out(spc), .mem_req_in(mreq), .mem_addr_lo_in(malo), .mem_size_in(msz),
    .mem_data_in(mdat), .mem_valid_out(mval), .mem_lane_out(lane), .mem_be_out(be),
    .mem_misalign_out(mis), .bcd_hi_out(bh), .bcd_lo_out(bl));

  // Free-running core clock, 100 ns period
  always #50 clk = ~clk;

  function automatic logic [31:0] msk(input logic [3:0] e);
    for (int i = 0; i < 4; i++) msk[8*i+:8] = {8{e[i]}};
  endfunction

  task automatic cmp(input logic [95:0] g, input logic [95:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic rst();
    rst_n = 0;
    repeat (8) @(negedge clk);
    rst_n = 1;
  endtask

  // Read request; general and index answers are due two edges later
  task automatic rd(input logic [3:0] s, input cpm_pkg::cpm_size_t z, input logic lg,
                    input logic [95:0] e);
    @(negedge clk); rd_en = 1; rsel = s; rsz = z; il = lg; q_rd.push_back(e);
    @(negedge clk); rd_en = 0;
  endtask

  task automatic gw(input logic [3:0] s, input cpm_pkg::cpm_size_t z, input logic [31:0] d);
    @(negedge clk); wr = {1'b1, s, z, d};
    @(negedge clk); wr.en = 0;
  endtask

  task automatic cm(input logic w, input logic [2:0] s, input logic [31:0] d,
                    input logic [95:0] e);
    @(negedge clk); ctl = {1'b1, w, cpm_pkg::cpm_ctl_t'(s), d}; q_ctl.push_back(e);
    @(negedge clk); ctl.en = 0;
  endtask

  // Track outstanding requests so the watcher knows when a result lands
  always @(posedge clk) begin
    rd_p <= rst_n ? {rd_p[0], rd_en} : 2'b00;
    ctl_p <= rst_n & ctl.en;
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Watcher: oldest note is taken off the queue when its result shows
  always @(negedge clk) begin
    if (rd_p[1]) cmp({rerr, rdat, idat}, q_rd.pop_front());
    if (ctl_p) cmp({perr, crd}, q_ctl.pop_front());
    if (mval) cmp({bh, bl, mis, be, lane & msk(be)}, q_ln.pop_front());
  end

  initial begin
    r = $urandom(33);
    rst();
    cmp({sup, sw}, {1'b1, 16'h2700});
    r = $urandom;
    gw(3, cpm_pkg::CPM_SZ_LONG, r);
    gw(3, cpm_pkg::CPM_SZ_BYTE, 32'h1234_56AB);
    rd(3, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, r[31:8], 8'hAB, r[31:8], 8'hAB});
    gw(0, cpm_pkg::CPM_SZ_LONG, 32'h0000_0001);
    rd(0, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, 32'h0000_0001, 32'h0000_0001});
    gw(10, cpm_pkg::CPM_SZ_WORD, 32'h0000_8001);
    rd(10, cpm_pkg::CPM_SZ_WORD, 0, {1'b0, 32'h0000_8001, 32'hFFFF_8001});
    gw(10, cpm_pkg::CPM_SZ_BYTE, 32'h0000_0000);
    cmp(werr, 1'b1);
    rd(10, cpm_pkg::CPM_SZ_BYTE, 1, {1'b1, 32'h0000_0000, 32'hFFFF_8001});
    // A general write colliding with a 64-bit result is dropped and flagged
    @(negedge clk); qen = 1; qh = 1; ql = 6; qd = {r, ~r};
    wr = {1'b1, 4'h2, cpm_pkg::CPM_SZ_LONG, r};
    @(negedge clk); qen = 0; wr.en = 0;
    cmp(werr, 1'b1);
    rd(1, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, r, r});
    rd(6, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, ~r, ~r});
    rd(2, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, 64'h0});
    cm(1, 1, 32'hFFFF_FFFF, {1'b0, 32'h0000_2700});
    cmp(sw, 16'hE71F);
    cm(0, 0, 0, {1'b0, 32'h0000_001F});
    cm(1, 1, 32'h0000_2700, {1'b0, 32'h0000_E71F});
    cm(1, 5, 0, {1'b1, 32'h0});
    cm(1, 3, 32'hFFFF_FFFD, {1'b0, 32'h0});
    cm(0, 3, 0, {1'b0, 32'h0000_0005});
    cm(1, 4, 32'hFFFF_FFFA, {1'b0, 32'h0});
    for (int i = 0; i < 5; i++) begin
      @(negedge clk); acc = cpm_pkg::cpm_acc_t'(i);
      @(negedge clk); cmp(spc, sx[i]);
    end
    r = $urandom;
    cm(1, 2, r, {1'b0, 32'h0});
    @(negedge clk); vreq = 1; disp = 10'h3FC;
    @(negedge clk); vreq = 0;
    cmp(vaddr, r + 32'h0000_03FC);
    // Every size at every offset; odd word and long offsets are refused
    for (int z = 0; z < 3; z++) for (int k = 0; k < 4; k++) begin
      r = $urandom;
      m = (z != 0) && k[0];
      case (z)
        0: begin b = 4'h8 >> k; l = {24'h0, r[7:0]} << (8 * (3 - k)); end
        1: begin b = m ? 4'h0 : (k == 0 ? 4'hC : 4'h3); l = k == 0 ? r << 16 : r & 32'hFFFF; end
        default: begin b = m ? 4'h0 : 4'hF; l = k == 0 ? r : {r[15:0], r[31:16]}; end
      endcase
      @(negedge clk); mreq = 1; msz = cpm_pkg::cpm_size_t'(z); malo = k; mdat = r;
      q_ln.push_back({r[7:4], r[3:0], m, b, l & msk(b)});
      @(negedge clk); mreq = 0;
    end
    repeat (3) @(negedge clk);
    rst();
    gw(15, cpm_pkg::CPM_SZ_LONG, 32'h0000_1000);
    rd(15, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, 32'h0000_1000, 32'h0000_1000});
    cm(1, 1, 0, {1'b0, 32'h0000_2700});
    rd(15, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, 32'h0, 32'h0});
    cm(0, 1, 0, {1'b1, 32'h0});
    cm(0, 2, 0, {1'b1, 32'h0});
    cm(1, 0, 32'hFFFF_FF0A, {1'b0, 32'h0});
    cmp(sw, 16'h000A);
    @(negedge clk); ccwe = 1; cc = 5'h15;
    @(negedge clk); ccwe = 0;
    cm(0, 0, 0, {1'b0, 32'h0000_0015});
    // Clock enable low: a write in that window must leave no trace
    ce = 0;
    gw(0, cpm_pkg::CPM_SZ_LONG, 32'hA5A5_A5A5);
    ce = 1;
    rd(0, cpm_pkg::CPM_SZ_LONG, 1, {1'b0, 64'h0});
    repeat (4) @(negedge clk);
    report_and_stop();
  end
endmodule // tb_cpm_regs
